/* dbs_pkg.sv */
`default_nettype none
package dbs_pkg;
   // spi instructions, msb first on the wire
   localparam logic [7:0] INSTR_DATA_READ       = 8'h03;
   localparam logic [7:0] INSTR_DATA_WRITE      = 8'h02;
   localparam logic [7:0] STATUS_READ_INSTR     = 8'h05;
   localparam logic [7:0] STATUS_WRITE_INSTR    = 8'h01;
   // shared bus select codes
   localparam logic [2:0] SELECT_CODE_NONE      = 3'h0;
   localparam logic [2:0] BANK_ZERO_SELECT_CODE = 3'h1;
   localparam logic [2:0] BANK_ONE_SELECT_CODE  = 3'h2;
   // status register mode field
   localparam int         MODE_MSB              = 7;
   localparam int         MODE_LSB              = 6;
   localparam logic [1:0] MODE_BYTE             = 2'h0;
   localparam logic [1:0] MODE_PAGE             = 2'h2;
   localparam logic [1:0] MODE_SEQ              = 2'h1;
   localparam logic [7:0] STATUS_RST            = 8'h01;
   // register port map
   localparam logic [2:0] REG_UADDR             = 3'h0;
   localparam logic [2:0] REG_UDATA             = 3'h1;
   localparam logic [2:0] REG_STAT0             = 3'h2;
   localparam logic [2:0] REG_STAT1             = 3'h3;
   localparam logic [2:0] REG_INFO              = 3'h4;
   localparam int         INFO_OVF_BIT          = 0;
   localparam int         INFO_LVL_LSB          = 8;
   localparam logic [2:0] BIT_LAST              = 3'h7;

   typedef enum logic [8:0] {
      ST_IDLE    = 9'b000000001,
      ST_CMD     = 9'b000000010,
      ST_ADDR_HI = 9'b000000100,
      ST_ADDR_LO = 9'b000001000,
      ST_DREAD   = 9'b000010000,
      ST_DWRITE  = 9'b000100000,
      ST_STAT_RD = 9'b001000000,
      ST_STAT_WR = 9'b010000000,
      ST_SKIP    = 9'b100000000
   } dbs_state_t;

   // reserved mode code 11 behaves as byte mode
   function automatic logic [1:0] mode_of(input logic [7:0] status);
      logic [1:0] m;
      m = status[MODE_MSB:MODE_LSB];
      mode_of = (m == MODE_PAGE || m == MODE_SEQ) ? m : MODE_BYTE;
   endfunction
endpackage
`default_nettype wire

/* dbs_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dbs_fifo_if #(
   parameter int W     = 24,
   parameter int DEPTH = 32
);
   logic                         in_valid;
   logic                         in_ready;
   logic [W-1:0]                 in_data;
   logic                         out_valid;
   logic                         out_ready;
   logic [W-1:0]                 out_data;
   logic [$clog2(DEPTH+1)-1:0]   level;
   modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, level);
   modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, level);
endinterface
`default_nettype wire

/* dbs_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module dbs_fifo #(
   parameter int W     = 24,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   dbs_fifo_if.fifo f
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   initial begin
      if (DEPTH < 2 || (1 << PW) != DEPTH)
         $error("fifo depth must be a power of two");
   end

   logic [W-1:0]  mem_r [DEPTH];
   logic [PW-1:0] wptr_r;
   logic [PW-1:0] rptr_r;
   logic [CW-1:0] cnt_r;
   logic          push;
   logic          pop;

   assign f.in_ready  = (cnt_r != CW'(DEPTH));
   assign f.out_valid = (cnt_r != '0);
   assign f.out_data  = mem_r[rptr_r];
   assign f.level     = cnt_r;
   assign push        = f.in_valid & f.in_ready;
   assign pop         = f.out_valid & f.out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wptr_r] <= f.in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + PW'(1);
         end
         if (pop) begin
            rptr_r <= rptr_r + PW'(1);
         end
         cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
   end
endmodule
`default_nettype wire

/* dbs_sram_access.sv */
// Summary of operation
// - each bank moves one byte, a 32-byte page, or an unbounded run per transfer.
// - in sequential mode data bytes follow the address back to back at rising addresses.
// - four instructions are decoded: data read 03h, status read 05h, status write 01h, data write.
// - the mode is set by a status write and holds until the next status write.
// - a 64 KB linear address picks the bank by its top bit and passes the rest to it.
// - the data write instruction is 02h followed by a 16-bit address.
// - status bits 7:6 give the mode: 00 byte, 10 page, 01 sequential.
// - serial words go msb first, one bit in and one bit out per clock.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dbs_sram_access #(
   parameter int BANK_BYTES = 32768,
   parameter int PAGE_BYTES = 32,
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [15:0] reg_rdata,
   input  wire logic [2:0]  spi_sel,
   input  wire logic        spi_sck,
   input  wire logic        spi_mosi,
   output var  logic        spi_miso,
   output var  logic        spi_miso_oe,
   output var  logic        wr_fifo_ready
);
   localparam int AW = $clog2(BANK_BYTES);
   localparam int PW = $clog2(PAGE_BYTES);
   localparam int FW = 1 + AW + 8;

   initial begin
      // the high address byte needs at least one bank bit above bit 7
      if ((1 << AW) != BANK_BYTES || AW > 15 || AW < 9)
         $error("bank size must be a power of two between 512 and 32768");
      if ((1 << PW) != PAGE_BYTES || PW >= AW)
         $error("page size must be a power of two below the bank size");
   end

   logic [7:0]        mem_r [2*BANK_BYTES];
   dbs_pkg::dbs_state_t state_r;
   logic              sck_q_r;
   logic [2:0]        bit_r;
   logic [6:0]        sh_in_r;
   logic [7:0]        sh_out_r;
   logic [AW-1:0]     addr_r;
   logic              is_read_r;
   logic              bank_r;
   logic [7:0]        status_r [2];
   logic [AW:0]       uaddr_r;
   logic              ovf_r;
   logic              selected;
   logic              sel_bank;
   logic              rise;
   logic              byte_done;
   logic [7:0]        byte_in;
   logic [1:0]        cur_mode;
   logic              bus_mem_wr;
   logic [AW-1:0]     addr_next;

   dbs_fifo_if #(.W(FW), .DEPTH(FIFO_DEPTH)) wq ();

   dbs_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wq (
      .clk   (clk),
      .rst_n (rst_n),
      .f     (wq)
   );

   // page mode wraps inside the page, sequential wraps inside the bank
   function automatic logic [AW-1:0] advance(input logic [AW-1:0] a, input logic [1:0] m);
      advance = (m == dbs_pkg::MODE_PAGE) ? {a[AW-1:PW], a[PW-1:0] + PW'(1)} : a + AW'(1);
   endfunction

   assign selected  = (spi_sel == dbs_pkg::BANK_ZERO_SELECT_CODE) ||
                      (spi_sel == dbs_pkg::BANK_ONE_SELECT_CODE);
   assign sel_bank  = (spi_sel == dbs_pkg::BANK_ONE_SELECT_CODE);
   assign rise      = spi_sck & ~sck_q_r;
   // a byte that ends on the deselect edge is dropped, never queued or stored
   assign byte_done = rise && (bit_r == dbs_pkg::BIT_LAST) && selected &&
                      (sel_bank == bank_r);
   assign byte_in   = {sh_in_r, spi_mosi};
   assign cur_mode  = dbs_pkg::mode_of(status_r[bank_r]);
   assign addr_next = advance(addr_r, cur_mode);
   assign bus_mem_wr = reg_wr && (reg_addr == dbs_pkg::REG_UDATA);

   // received bytes queue here so the byte write port can be shared with software
   assign wq.in_valid  = (state_r == dbs_pkg::ST_DWRITE) && byte_done;
   assign wq.in_data   = {bank_r, addr_r, byte_in};
   assign wq.out_ready = ~bus_mem_wr;

   always_ff @(posedge clk) begin
      if (bus_mem_wr) begin
         mem_r[uaddr_r] <= reg_wdata[7:0];
      end else if (wq.out_valid) begin
         mem_r[wq.out_data[FW-1:8]] <= wq.out_data[7:0];
      end
   end

   // serial engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= dbs_pkg::ST_IDLE;
         sck_q_r   <= 1'b0;
         bit_r     <= '0;
         sh_in_r   <= '0;
         sh_out_r  <= '0;
         addr_r    <= '0;
         is_read_r <= 1'b0;
         bank_r    <= 1'b0;
      end else begin
         sck_q_r <= spi_sck;
         if (!selected || (state_r != dbs_pkg::ST_IDLE && sel_bank != bank_r)) begin
            state_r  <= dbs_pkg::ST_IDLE;
            bit_r    <= '0;
            sh_out_r <= '0;
         end else if (state_r == dbs_pkg::ST_IDLE) begin
            state_r <= dbs_pkg::ST_CMD;
            bank_r  <= sel_bank;
            bit_r   <= '0;
         end else if (rise) begin
            bit_r    <= bit_r + 3'h1;
            sh_in_r  <= byte_in[6:0];
            sh_out_r <= {sh_out_r[6:0], 1'b0};
            if (byte_done) begin
               sh_out_r <= '0;
               case (state_r)
                  dbs_pkg::ST_CMD: begin
                     case (byte_in)
                        dbs_pkg::INSTR_DATA_READ: begin
                           is_read_r <= 1'b1;
                           state_r   <= dbs_pkg::ST_ADDR_HI;
                        end
                        dbs_pkg::INSTR_DATA_WRITE: begin
                           is_read_r <= 1'b0;
                           state_r   <= dbs_pkg::ST_ADDR_HI;
                        end
                        dbs_pkg::STATUS_READ_INSTR: begin
                           sh_out_r <= status_r[bank_r];
                           state_r  <= dbs_pkg::ST_STAT_RD;
                        end
                        dbs_pkg::STATUS_WRITE_INSTR: begin
                           state_r <= dbs_pkg::ST_STAT_WR;
                        end
                        default: begin
                           state_r <= dbs_pkg::ST_SKIP;
                        end
                     endcase
                  end
                  dbs_pkg::ST_ADDR_HI: begin
                     // address bits above the bank size are ignored
                     addr_r[AW-1:8] <= byte_in[AW-9:0];
                     state_r        <= dbs_pkg::ST_ADDR_LO;
                  end
                  dbs_pkg::ST_ADDR_LO: begin
                     addr_r[7:0] <= byte_in;
                     if (is_read_r) begin
                        sh_out_r <= mem_r[{bank_r, addr_r[AW-1:8], byte_in}];
                        state_r  <= dbs_pkg::ST_DREAD;
                     end else begin
                        state_r <= dbs_pkg::ST_DWRITE;
                     end
                  end
                  dbs_pkg::ST_DREAD, dbs_pkg::ST_DWRITE: begin
                     addr_r <= addr_next;
                     if (cur_mode == dbs_pkg::MODE_BYTE) begin
                        state_r <= dbs_pkg::ST_SKIP;
                     end else if (state_r == dbs_pkg::ST_DREAD) begin
                        sh_out_r <= mem_r[{bank_r, addr_next}];
                     end
                  end
                  dbs_pkg::ST_STAT_RD: begin
                     sh_out_r <= status_r[bank_r];
                  end
                  dbs_pkg::ST_STAT_WR: begin
                     state_r <= dbs_pkg::ST_SKIP;
                  end
                  default: begin
                     state_r <= dbs_pkg::ST_SKIP;
                  end
               endcase
            end
         end
      end
   end

   // mode persists until the next status write from either side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r[0] <= dbs_pkg::STATUS_RST;
         status_r[1] <= dbs_pkg::STATUS_RST;
      end else begin
         if (reg_wr && reg_addr == dbs_pkg::REG_STAT0) begin
            status_r[0] <= reg_wdata[7:0];
         end
         if (reg_wr && reg_addr == dbs_pkg::REG_STAT1) begin
            status_r[1] <= reg_wdata[7:0];
         end
         if (state_r == dbs_pkg::ST_STAT_WR && byte_done) begin
            status_r[bank_r] <= byte_in;
         end
      end
   end

   // register port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uaddr_r   <= '0;
         reg_rdata <= '0;
         ovf_r     <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == dbs_pkg::REG_UADDR) begin
            uaddr_r <= reg_wdata[AW:0];
         end
         // a new overflow beats a simultaneous clear
         if (wq.in_valid && !wq.in_ready) begin
            ovf_r <= 1'b1;
         end else if (reg_wr && reg_addr == dbs_pkg::REG_INFO && reg_wdata[dbs_pkg::INFO_OVF_BIT]) begin
            ovf_r <= 1'b0;
         end
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               dbs_pkg::REG_UADDR: reg_rdata <= 16'(uaddr_r);
               dbs_pkg::REG_UDATA: reg_rdata <= {8'h00, mem_r[uaddr_r]};
               dbs_pkg::REG_STAT0: reg_rdata <= {8'h00, status_r[0]};
               dbs_pkg::REG_STAT1: reg_rdata <= {8'h00, status_r[1]};
               dbs_pkg::REG_INFO:  reg_rdata <= 16'({wq.level, 7'h00, ovf_r});
               default:            reg_rdata <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spi_miso      <= 1'b0;
         spi_miso_oe   <= 1'b0;
         wr_fifo_ready <= 1'b0;
      end else begin
         spi_miso      <= sh_out_r[7];
         spi_miso_oe   <= selected && state_r != dbs_pkg::ST_IDLE;
         wr_fifo_ready <= wq.in_ready;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_DESELECT_ENDS: assert property (!selected |=> state_r == dbs_pkg::ST_IDLE)
      else $error("deselect did not end the transfer");
   AST_READ_DECODE: assert property (state_r == dbs_pkg::ST_CMD && byte_done &&
      byte_in == dbs_pkg::INSTR_DATA_READ && selected && sel_bank == bank_r
      |=> state_r == dbs_pkg::ST_ADDR_HI && is_read_r)
      else $error("read instruction not decoded");
   AST_WRITE_DECODE: assert property (state_r == dbs_pkg::ST_CMD && byte_done &&
      byte_in == dbs_pkg::INSTR_DATA_WRITE && selected && sel_bank == bank_r
      |=> state_r == dbs_pkg::ST_ADDR_HI && !is_read_r)
      else $error("write instruction not decoded");
   AST_MSB_FIRST: assert property (rise && !byte_done && state_r == dbs_pkg::ST_DREAD &&
      selected && sel_bank == bank_r |=> ##1 spi_miso == $past(sh_out_r[6], 2))
      else $error("read data not shifted msb first");
   AST_SEQ_ADVANCE: assert property (byte_done && state_r == dbs_pkg::ST_DREAD && selected &&
      sel_bank == bank_r && cur_mode == dbs_pkg::MODE_SEQ |=> addr_r == $past(addr_r) + AW'(1))
      else $error("sequential address did not advance");
   AST_PAGE_STAYS: assert property (byte_done && state_r == dbs_pkg::ST_DWRITE && selected &&
      sel_bank == bank_r && cur_mode == dbs_pkg::MODE_PAGE
      |=> addr_r[AW-1:PW] == $past(addr_r[AW-1:PW]))
      else $error("page transfer left its page");
   AST_BYTE_STOPS: assert property (byte_done && state_r == dbs_pkg::ST_DWRITE && selected &&
      sel_bank == bank_r && cur_mode == dbs_pkg::MODE_BYTE |=> state_r == dbs_pkg::ST_SKIP)
      else $error("byte mode took a second byte");
   AST_MODE_WRITE: assert property (byte_done && state_r == dbs_pkg::ST_STAT_WR && selected &&
      sel_bank == bank_r && !reg_wr |=> status_r[bank_r] == $past(byte_in))
      else $error("status write lost");
   AST_MODE_HOLDS: assert property (!reg_wr && state_r != dbs_pkg::ST_STAT_WR
      |=> $stable(status_r[0]) && $stable(status_r[1]))
      else $error("mode changed without a status write");
   AST_UNIFIED_BANK: assert property (wq.in_valid |-> wq.in_data[FW-1] == sel_bank)
      else $error("queued write carries the wrong bank");

   COV_SEQ_READ: cover property (state_r == dbs_pkg::ST_DREAD && byte_done &&
      cur_mode == dbs_pkg::MODE_SEQ);
   COV_PAGE_WRITE: cover property (state_r == dbs_pkg::ST_DWRITE && byte_done &&
      cur_mode == dbs_pkg::MODE_PAGE);
   COV_STATUS_WRITE: cover property (state_r == dbs_pkg::ST_STAT_WR && byte_done);
   COV_FIFO_FULL: cover property (!wq.in_ready);
endmodule
`default_nettype wire

/* dbs_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none
module dbs_spi_master (
   input  wire logic       clk,
   input  wire logic       miso,
   output var  logic [2:0] sel,
   output var  logic       sck,
   output var  logic       mosi,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_byte
);
   // sck high time in clk cycles, low time one less; raised by the bench for slow frames
   int         half = 4;
   logic [7:0] rx;

   initial begin
      sel      = 3'h0;
      sck      = 1'b0;
      mosi     = 1'b0;
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
      rx       = 8'h00;
   end

   // code set while sck is low, settles before the first rise
   task automatic open_bank(input logic [2:0] code);
      @(posedge clk);
      sel <= code;
      repeat (2) @(posedge clk);
   endtask

   // one bit out and one bit in per clock; miso taken at the rise
   task automatic xfer(input logic [7:0] tx, input bit chk);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk);
         sck  <= 1'b0;
         mosi <= tx[i];
         repeat (half - 1) @(posedge clk);
         sck   <= 1'b1;
         rx[i] = miso;
         repeat (half - 1) @(posedge clk);
      end
      if (chk) begin
         rx_byte  <= rx;
         rx_valid <= 1'b1;
         @(posedge clk);
         rx_valid <= 1'b0;
      end
   endtask

   // sck parked low before deselect so no stray edge lands in a frame
   task automatic close_bank();
      @(posedge clk);
      sck  <= 1'b0;
      mosi <= 1'b0;
      repeat (2) @(posedge clk);
      sel <= 3'h0;
      repeat (3) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk;
   logic        rst_n;
   logic [2:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [2:0]  spi_sel;
   logic        spi_sck;
   logic        spi_mosi;
   logic        spi_miso;
   logic        spi_miso_oe;
   logic        wr_fifo_ready;
   logic        miso_last;
   logic        miso_w;
   logic        rx_valid;
   logic [7:0]  rx_byte;
   logic        rd_seen;
   int          err_total;
   int          samples_checked;
   int          seed;
   logic [15:0] exp_reg[$];
   logic [7:0]  exp_spi[$];
   logic [7:0]  data[6];
   logic [15:0] base;
   logic [1:0]  modes[4];

   dbs_sram_access dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .spi_sel(spi_sel), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .wr_fifo_ready(wr_fifo_ready));
   dbs_spi_master mst_u (.clk(clk), .miso(miso_w), .sel(spi_sel), .sck(spi_sck),
      .mosi(spi_mosi), .rx_valid(rx_valid), .rx_byte(rx_byte));

   // released wire shows the inverse, never a stale copy
   assign miso_w = spi_miso_oe ? spi_miso : ~miso_last;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         miso_last <= 1'b0;
         rd_seen   <= 1'b0;
      end else begin
         if (spi_miso_oe) miso_last <= spi_miso;
         rd_seen <= reg_rd;
      end
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   always @(negedge clk) begin
      if (rd_seen) cmp(reg_rdata, exp_reg.size() ? exp_reg.pop_front() : 16'hXXXX);
      if (rx_valid) cmp({8'h00, rx_byte}, {8'h00, exp_spi.size() ? exp_spi.pop_front() : 8'hXX});
   end

   task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [2:0] a, input logic [15:0] e);
      exp_reg.push_back(e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   task automatic u_wr(input logic [15:0] a, input logic [7:0] d);
      reg_write(dbs_pkg::REG_UADDR, a);
      reg_write(dbs_pkg::REG_UDATA, {8'h00, d});
   endtask

   task automatic u_rd(input logic [15:0] a, input logic [7:0] e);
      reg_write(dbs_pkg::REG_UADDR, a);
      reg_read(dbs_pkg::REG_UDATA, {8'h00, e});
   endtask

   task automatic spi_open(input logic [2:0] b, input logic [7:0] ins, input logic [15:0] a,
                           input bit has_addr);
      mst_u.open_bank(b);
      mst_u.xfer(ins, 1'b0);
      if (has_addr) begin
         mst_u.xfer(a[15:8], 1'b0);
         mst_u.xfer(a[7:0], 1'b0);
      end
   endtask

   task automatic spi_rd(input logic [7:0] e);
      exp_spi.push_back(e);
      mst_u.xfer(8'h00, 1'b1);
   endtask

   task automatic stat_wr(input logic [2:0] b, input logic [7:0] v);
      spi_open(b, dbs_pkg::STATUS_WRITE_INSTR, 16'h0000, 1'b0);
      mst_u.xfer(v, 1'b0);
      mst_u.close_bank();
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      $display("MISMATCH at %0t: run timed out", $time);
      print_verdict();
   end

   initial begin
      seed = 98;
      err_total = 0;
      samples_checked = 0;
      // reserved code 11 is stored as written; page last so bank one ends in page mode
      modes = '{dbs_pkg::MODE_BYTE, dbs_pkg::MODE_SEQ, 2'h3, dbs_pkg::MODE_PAGE};
      rst_n <= 1'b0;
      reg_addr <= 3'h0;
      reg_wdata <= 16'h0000;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      cmp({14'h0000, wr_fifo_ready, spi_miso_oe}, 16'h0000);
      cmp(reg_rdata, 16'h0000);
      @(negedge clk);
      cmp({14'h0000, wr_fifo_ready, spi_miso_oe}, 16'h0002);
      reg_read(dbs_pkg::REG_STAT0, {8'h00, dbs_pkg::STATUS_RST});
      reg_read(dbs_pkg::REG_STAT1, {8'h00, dbs_pkg::STATUS_RST});
      reg_read(dbs_pkg::REG_INFO, 16'h0000);
      reg_write(3'h5, 16'hFFFF);
      reg_read(3'h5, 16'h0000);
      // status read repeats the status on every byte
      spi_open(dbs_pkg::BANK_ZERO_SELECT_CODE, dbs_pkg::STATUS_READ_INSTR, 16'h0000, 1'b0);
      spi_rd(8'h01);
      spi_rd(8'h01);
      mst_u.close_bank();
      for (int i = 0; i < 4; i++) begin
         stat_wr(dbs_pkg::BANK_ONE_SELECT_CODE, {modes[i], 6'h01});
         reg_read(dbs_pkg::REG_STAT1, {8'h00, modes[i], 6'h01});
      end
      stat_wr(dbs_pkg::BANK_ZERO_SELECT_CODE, {dbs_pkg::MODE_SEQ, 6'h01});
      // sequential run on a slow clock, then read back in a new frame
      base = 16'($random(seed)) & 16'h7FF0;
      mst_u.half = 6;
      spi_open(dbs_pkg::BANK_ZERO_SELECT_CODE, dbs_pkg::INSTR_DATA_WRITE, base, 1'b1);
      for (int i = 0; i < 6; i++) begin
         data[i] = 8'($random(seed));
         mst_u.xfer(data[i], 1'b0);
      end
      mst_u.close_bank();
      mst_u.half = 4;
      spi_open(dbs_pkg::BANK_ZERO_SELECT_CODE, dbs_pkg::INSTR_DATA_READ, base, 1'b1);
      for (int i = 0; i < 6; i++) spi_rd(data[i]);
      mst_u.close_bank();
      u_rd(base + 16'h0005, data[5]);
      // page mode wraps inside its 32-byte page, next page untouched
      u_wr(16'h8060, 8'hC3);
      spi_open(dbs_pkg::BANK_ONE_SELECT_CODE, dbs_pkg::INSTR_DATA_WRITE, 16'h005E, 1'b1);
      for (int i = 0; i < 4; i++) mst_u.xfer(8'h10 + 8'(i), 1'b0);
      mst_u.close_bank();
      for (int i = 0; i < 4; i++) u_rd(16'h8040 + 16'((i + 30) % 32), 8'h10 + 8'(i));
      u_rd(16'h8060, 8'hC3);
      // byte mode takes only the first data byte
      reg_write(dbs_pkg::REG_STAT0, {8'h00, dbs_pkg::MODE_BYTE, 6'h01});
      u_wr(16'h0101, 8'h77);
      spi_open(dbs_pkg::BANK_ZERO_SELECT_CODE, dbs_pkg::INSTR_DATA_WRITE, 16'h0100, 1'b1);
      mst_u.xfer(8'h11, 1'b0);
      mst_u.xfer(8'h22, 1'b0);
      mst_u.close_bank();
      u_rd(16'h0100, 8'h11);
      u_rd(16'h0101, 8'h77);
      // unified write lands in bank one at the in-bank offset
      u_wr(16'h8123, 8'h5A);
      spi_open(dbs_pkg::BANK_ONE_SELECT_CODE, dbs_pkg::INSTR_DATA_READ, 16'h0123, 1'b1);
      spi_rd(8'h5A);
      mst_u.close_bank();
      repeat (10) @(posedge clk);
      if (exp_reg.size() != 0 || exp_spi.size() != 0) begin
         err_total++;
         $display("MISMATCH at %0t: results missing", $time);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
